// ---- src/can_rxfifo_map.vh ----
// register offsets, field positions and reset values of the receive fifo path
`ifndef CAN_RXFIFO_MAP_VH
`define CAN_RXFIFO_MAP_VH

// ==========================================================
// register byte offsets
`define OFS_FIFO_CFG 8'h00
`define OFS_FIFO_STS 8'h04
`define OFS_PTR_CTRL 8'h08
`define OFS_GLB_CFG 8'h0C
`define OFS_RULE_ID 8'h10
`define OFS_RULE_MASK 8'h14
`define OFS_RULE_CFG 8'h18
`define OFS_ENT_ID_LO 8'h20
`define OFS_ENT_ID_HI 8'h24
`define OFS_ENT_TS 8'h28
`define OFS_ENT_PTR 8'h2C
`define OFS_ENT_DF0 8'h30
`define OFS_ENT_DF1 8'h34

// ==========================================================
// fifo_cfg fields
`define CFG_USE_EN 0
`define CFG_MODE_LO 1
`define CFG_MODE_HI 2
`define CFG_RX_IE 3
`define CFG_IRQ_MODE 4
`define CFG_THR_LO 5
`define CFG_THR_HI 7
`define CFG_DEPTH_LO 8
`define CFG_DEPTH_HI 10
`define CFG_FULL_IE 11
`define CFG_ONE_IE 12
`define CFG_OVW_MODE 13
`define CFG_THIST_EN 14
`define CFG_WIDTH 15
`define CFG_RESET 15'h0000

// ==========================================================
// fifo_sts fields
`define STS_EMPTY 0
`define STS_FULL 1
`define STS_LOST 2
`define STS_OVW 3
`define STS_RX_IF 4
`define STS_FULL_IF 5
`define STS_ONE_IF 6
`define STS_CNT_LO 8
`define STS_CNT_HI 15

// ==========================================================
// glb_cfg fields
`define GLB_DLC_CHK 0
`define GLB_LOST_IE 1
`define GLB_OVW_IE 2
`define GLB_PAGE 3
`define GLB_MIRROR 4
`define GLB_WIDTH 5
`define GLB_RESET 5'h00

// ==========================================================
// rule_cfg fields
`define RC_DLC_LO 0
`define RC_DLC_HI 3
`define RC_DLC_REPL 4
`define RC_DEST_FIFO 5
`define RC_LABEL_LO 16
`define RC_LABEL_HI 31

// ==========================================================
// constants
`define MODE_RECEIVE 2'b00
`define PTR_ADVANCE_KEY 8'hFF
`define DEPTH_BASE 8'h04
`define PAYLOAD_BYTES 4'h8

`endif

// ---- src/can_rxfifo_path.v ----
// receive-mode path of a per-channel can transmit/receive fifo, apb slave
//
// What this block does
// R1 - entry registers read only in receive mode with ram page one
// R2 - tx history store enable has no effect in receive mode
// R3 - standard id sits in low bits 10:0, other id bits read zero
// R4 - dlc replaced by rule dlc when check and replace both enabled
// R5 - each stored message carries the matched rule's 16-bit label
// R6 - data bytes beyond the received dlc read as zero
// R7 - software writes ff to pointer control after reading a message
// R8 - software advances only when fifo enabled and not empty
// R9 - unread count increments on each stored message
// R10 - full flag set when count equals the selected depth
// R11 - empty flag set once every message has been released
// R12 - messages read out oldest first
// R13 - valid advance releases oldest entry and decrements count
// R14 - mode 0: rx request when fill reaches selected threshold
// R15 - mode 1: rx request on every completed reception
// R16 - odd eighths thresholds not used with four-message depth
// R17 - per-fifo rx interrupt enable gates the rx interrupt
// R18 - request flags survive fifo disable, cleared only by writing 0
// R19 - full flag and interrupt when fifo becomes full if enabled
// R20 - one-frame flag and interrupt on one-frame store if enabled
// R21 - lost message flagged, global error if lost enable set
// R22 - overwrite raises global error if overwrite enable set
// R23 - full and overwrite mode: replace oldest, advance, flag overwrite
// R24 - full and not overwrite mode: discard, flag message lost
// R25 - filter on ide, rtr, id under masks, dlc check, route, label
// R26 - with mirror on, rule selects own or other node frames
`timescale 1ns/10ps
`include "can_rxfifo_map.vh"

module can_rxfifo_path #(
    parameter AW = 4,
    parameter TS_W = 16
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // received frame from the protocol controller, same clock
    input wire frm_valid,
    input wire frm_ide,
    input wire frm_rtr,
    input wire [28:0] frm_id,
    input wire [3:0] frm_dlc,
    input wire [63:0] frm_data,
    input wire [TS_W-1:0] frm_timestamp,
    input wire frm_own_tx,
    input wire frm_one_frame,
    // interrupts
    output reg rx_irq,
    output reg full_irq,
    output reg global_err_irq
);

    localparam MAX_DEPTH = 1 << AW;
    localparam EW = 1 + 1 + 29 + TS_W + 4 + 16 + 64;

    // ==========================================================
    // configuration registers
    reg [`CFG_WIDTH-1:0] fifo_cfg_r;
    reg [`GLB_WIDTH-1:0] glb_cfg_r;
    reg [31:0] rule_id_r;
    reg [30:0] rule_mask_r;
    reg [31:0] rule_cfg_r;

    wire fifo_use_enable = fifo_cfg_r[`CFG_USE_EN];
    wire [1:0] fifo_direction_mode = fifo_cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
    wire rx_irq_enable = fifo_cfg_r[`CFG_RX_IE];
    wire rx_irq_mode = fifo_cfg_r[`CFG_IRQ_MODE];
    wire [2:0] rx_irq_fill_threshold = fifo_cfg_r[`CFG_THR_HI:`CFG_THR_LO];
    wire [2:0] fifo_depth_select = fifo_cfg_r[`CFG_DEPTH_HI:`CFG_DEPTH_LO];
    wire full_irq_enable = fifo_cfg_r[`CFG_FULL_IE];
    wire one_frame_irq_enable = fifo_cfg_r[`CFG_ONE_IE];
    wire full_overwrite_mode = fifo_cfg_r[`CFG_OVW_MODE];
    wire global_dlc_check_enable = glb_cfg_r[`GLB_DLC_CHK];
    wire message_lost_irq_enable = glb_cfg_r[`GLB_LOST_IE];
    wire overwrite_irq_enable = glb_cfg_r[`GLB_OVW_IE];
    wire ram_window_page_select = glb_cfg_r[`GLB_PAGE];
    wire mirror_enable = glb_cfg_r[`GLB_MIRROR];
    wire [3:0] rule_dlc_value = rule_cfg_r[`RC_DLC_HI:`RC_DLC_LO];
    wire dlc_replace_enable = rule_cfg_r[`RC_DLC_REPL];
    wire [15:0] rule_label_value = rule_cfg_r[`RC_LABEL_HI:`RC_LABEL_LO];

    // tx_history_store_enable is stored and read back only
    wire rx_mode = (fifo_direction_mode == `MODE_RECEIVE); // R2

    // ==========================================================
    // fifo state
    reg [EW-1:0] mem [0:MAX_DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [7:0] unread_message_count_r;
    reg fifo_full_flag_r;
    reg fifo_empty_flag_r;
    reg msg_lost_flag_r;
    reg msg_ovw_flag_r;
    reg rx_irq_request_flag_r;
    reg full_irq_request_flag_r;
    reg one_frame_irq_request_flag_r;

    // depth: zero for code 0, else 4 << (code-1), clipped to the array size
    reg [8:0] depth;
    always @*
    begin
        if (fifo_depth_select == 3'd0)
            depth = 9'd0;
        else
            depth = {1'b0, `DEPTH_BASE} << (fifo_depth_select - 3'd1);
        if (depth > MAX_DEPTH)
            depth = MAX_DEPTH[8:0];
    end

    // fill level giving the rx request in threshold mode
    wire [11:0] thr_prod = depth * ({1'b0, rx_irq_fill_threshold} + 4'd1);
    wire [8:0] thr_level = thr_prod[11:3]; // R14

    // ==========================================================
    // receive filter
    wire [30:0] frm_key = {frm_rtr, frm_ide, frm_id};
    wire [30:0] rule_key = {rule_id_r[30], rule_id_r[29], rule_id_r[28:0]};
    wire id_match = ((frm_key ^ rule_key) & rule_mask_r) == 31'd0; // R25
    wire src_match = mirror_enable ? (frm_own_tx == rule_id_r[31])
                                   : !frm_own_tx; // R26
    wire dlc_ok = !global_dlc_check_enable ||
                  (frm_dlc >= rule_dlc_value); // R25
    wire accept = frm_valid && id_match && src_match && dlc_ok &&
                  rule_cfg_r[`RC_DEST_FIFO] && fifo_use_enable && rx_mode;

    wire [3:0] stored_dlc = (global_dlc_check_enable && dlc_replace_enable)
                            ? rule_dlc_value : frm_dlc; // R4

    // unfilled payload bytes are cleared before storing
    wire [3:0] fill_bytes = (frm_dlc > `PAYLOAD_BYTES) ? `PAYLOAD_BYTES
                                                       : frm_dlc;
    reg [63:0] padded_data;
    integer b;
    always @*
    begin
        padded_data = 64'h0000_0000_0000_0000;
        for (b = 0; b < 8; b = b + 1)
            if (b < fill_bytes)
                padded_data[b*8 +: 8] = frm_data[b*8 +: 8]; // R6
    end

    wire [EW-1:0] entry = {frm_ide, frm_rtr, frm_id, frm_timestamp,
                           stored_dlc, rule_label_value, padded_data}; // R5

    // ==========================================================
    // apb decode
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pready && pwrite;
    wire wr_cfg = apb_wr && (paddr == `OFS_FIFO_CFG);
    wire wr_sts = apb_wr && (paddr == `OFS_FIFO_STS);
    wire wr_ptr = apb_wr && (paddr == `OFS_PTR_CTRL);

    // advance only when software may legally do so
    wire advance = wr_ptr && (pwdata[7:0] == `PTR_ADVANCE_KEY) &&
                   fifo_use_enable && !fifo_empty_flag_r; // R8

    wire at_full = (unread_message_count_r == depth[7:0]) ||
                   (depth == 9'd0);
    // an advance in the same cycle frees a slot first
    wire room = !at_full || advance;
    wire do_store = accept && room;
    wire do_ovw = accept && !room && full_overwrite_mode && depth != 9'd0;
    wire do_lost = accept && !room && !do_ovw; // R24

    // ==========================================================
    // fifo pointers and count
    reg [7:0] count_nxt;
    always @*
    begin
        count_nxt = unread_message_count_r;
        if (do_store && !advance)
            count_nxt = unread_message_count_r + 8'd1; // R9
        else if (advance && !do_store)
            count_nxt = unread_message_count_r - 8'd1; // R13
    end

    wire [AW-1:0] depth_last = depth[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
    wire [AW-1:0] wr_ptr_inc = (wr_ptr_r == depth_last) ? {AW{1'b0}}
                               : wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
    wire [AW-1:0] rd_ptr_inc = (rd_ptr_r == depth_last) ? {AW{1'b0}}
                               : rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};

    wire full_nxt = (count_nxt == depth[7:0]) && (depth != 9'd0); // R10
    wire reach_thr = (count_nxt == thr_level[7:0]) &&
                     (count_nxt != unread_message_count_r);
    wire rx_event = rx_irq_mode ? (do_store || do_ovw) // R15
                                : (do_store && reach_thr); // R14

    always @(posedge pclk)
    begin
        if (do_store || do_ovw)
            mem[wr_ptr_r] <= entry;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            unread_message_count_r <= 8'h00;
            fifo_full_flag_r <= 1'b0;
            fifo_empty_flag_r <= 1'b1;
        end
        else if (!fifo_use_enable)
        begin
            // disabling the fifo drops its content
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            unread_message_count_r <= 8'h00;
            fifo_full_flag_r <= 1'b0;
            fifo_empty_flag_r <= 1'b1;
        end
        else
        begin
            if (do_store || do_ovw)
                wr_ptr_r <= wr_ptr_inc;
            if (advance || do_ovw)
                rd_ptr_r <= rd_ptr_inc; // R23
            unread_message_count_r <= count_nxt;
            fifo_full_flag_r <= full_nxt;
            fifo_empty_flag_r <= (count_nxt == 8'h00); // R11
        end
    end

    // ==========================================================
    // sticky flags: hardware set wins over a software clear
    wire full_evt = full_irq_enable && full_nxt && !fifo_full_flag_r &&
                    fifo_use_enable; // R19
    wire one_evt = one_frame_irq_enable && frm_one_frame &&
                   (do_store || do_ovw); // R20

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            msg_lost_flag_r <= 1'b0;
            msg_ovw_flag_r <= 1'b0;
            rx_irq_request_flag_r <= 1'b0;
            full_irq_request_flag_r <= 1'b0;
            one_frame_irq_request_flag_r <= 1'b0;
        end
        else
        begin
            // a written 0 clears, fifo disable leaves them alone
            msg_lost_flag_r <= do_lost ||
                (msg_lost_flag_r && !(wr_sts && !pwdata[`STS_LOST])); // R24
            msg_ovw_flag_r <= do_ovw ||
                (msg_ovw_flag_r && !(wr_sts && !pwdata[`STS_OVW])); // R23
            rx_irq_request_flag_r <= rx_event || (rx_irq_request_flag_r &&
                !(wr_sts && !pwdata[`STS_RX_IF])); // R18
            full_irq_request_flag_r <= full_evt || (full_irq_request_flag_r &&
                !(wr_sts && !pwdata[`STS_FULL_IF])); // R18
            one_frame_irq_request_flag_r <= one_evt ||
                (one_frame_irq_request_flag_r &&
                !(wr_sts && !pwdata[`STS_ONE_IF])); // R18
        end
    end

    // ==========================================================
    // interrupt outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_irq <= 1'b0;
            full_irq <= 1'b0;
            global_err_irq <= 1'b0;
        end
        else
        begin
            rx_irq <= rx_irq_request_flag_r && rx_irq_enable; // R17
            full_irq <= (full_irq_request_flag_r && full_irq_enable) ||
                (one_frame_irq_request_flag_r && one_frame_irq_enable); // R20
            global_err_irq <= (msg_lost_flag_r && message_lost_irq_enable) ||
                (msg_ovw_flag_r && overwrite_irq_enable); // R21 R22
        end
    end

    // ==========================================================
    // configuration writes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fifo_cfg_r <= `CFG_RESET;
            glb_cfg_r <= `GLB_RESET;
            rule_id_r <= 32'h0000_0000;
            rule_mask_r <= 31'h0000_0000;
            rule_cfg_r <= 32'h0000_0000;
        end
        else
        begin
            if (wr_cfg)
                fifo_cfg_r <= pwdata[`CFG_WIDTH-1:0];
            if (apb_wr && paddr == `OFS_GLB_CFG)
                glb_cfg_r <= pwdata[`GLB_WIDTH-1:0];
            if (apb_wr && paddr == `OFS_RULE_ID)
                rule_id_r <= pwdata;
            if (apb_wr && paddr == `OFS_RULE_MASK)
                rule_mask_r <= pwdata[30:0];
            if (apb_wr && paddr == `OFS_RULE_CFG)
                rule_cfg_r <= pwdata;
        end
    end

    // ==========================================================
    // read side: oldest entry sits at the read pointer
    wire [EW-1:0] head = mem[rd_ptr_r]; // R12
    wire head_ide = head[EW-1];
    wire head_rtr = head[EW-2];
    wire [28:0] stored_identifier = head[EW-3:EW-31];
    wire [TS_W-1:0] head_ts = head[83+TS_W:84];
    wire [3:0] head_dlc = head[83:80];
    wire [15:0] head_label = head[79:64];
    wire [63:0] head_data = head[63:0];
    wire entry_visible = rx_mode && ram_window_page_select &&
                         !fifo_empty_flag_r; // R1

    // standard frames show only 11 id bits
    wire [15:0] id_lo = head_ide ? stored_identifier[15:0]
                                 : {5'b00000, stored_identifier[10:0]}; // R3
    wire [12:0] id_hi = head_ide ? stored_identifier[28:16] : 13'h0000; // R3

    reg [31:0] rd_mux;
    reg rd_hit;
    always @*
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `OFS_FIFO_CFG: rd_mux = {17'h0_0000, fifo_cfg_r};
            `OFS_FIFO_STS: rd_mux = {16'h0000, unread_message_count_r,
                1'b0, one_frame_irq_request_flag_r, full_irq_request_flag_r,
                rx_irq_request_flag_r, msg_ovw_flag_r, msg_lost_flag_r,
                fifo_full_flag_r, fifo_empty_flag_r};
            `OFS_PTR_CTRL: rd_mux = 32'h0000_0000;
            `OFS_GLB_CFG: rd_mux = {27'h000_0000, glb_cfg_r};
            `OFS_RULE_ID: rd_mux = rule_id_r;
            `OFS_RULE_MASK: rd_mux = {1'b0, rule_mask_r};
            `OFS_RULE_CFG: rd_mux = rule_cfg_r;
            `OFS_ENT_ID_LO: rd_mux = entry_visible ? {16'h0000, id_lo}
                                                   : 32'h0000_0000; // R1
            `OFS_ENT_ID_HI: rd_mux = entry_visible ?
                {16'h0000, head_ide, head_rtr, 1'b0, id_hi} : 32'h0000_0000;
            `OFS_ENT_TS: rd_mux = entry_visible ?
                {{(32-TS_W){1'b0}}, head_ts} : 32'h0000_0000;
            `OFS_ENT_PTR: rd_mux = entry_visible ?
                {head_dlc, 12'h000, head_label} : 32'h0000_0000;
            `OFS_ENT_DF0: rd_mux = entry_visible ? head_data[31:0]
                                                 : 32'h0000_0000;
            `OFS_ENT_DF1: rd_mux = entry_visible ? head_data[63:32]
                                                 : 32'h0000_0000;
            default: rd_hit = 1'b0;
        endcase
    end

    // ==========================================================
    // apb answer: registered in setup, one access cycle, no wait
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= apb_setup && !rd_hit;
            if (apb_setup && !pwrite)
                prdata <= rd_mux;
        end
    end

endmodule // can_rxfifo_path

// ---- tb/can_frame_src.sv ----
// frame source standing in for the protocol controller and filter feed
`timescale 1ns/10ps

module can_frame_src (
    // clock
    input wire pclk,
    // frame offer
    output wire frm_valid,
    output wire frm_ide,
    output wire frm_rtr,
    output wire [28:0] frm_id,
    output wire [3:0] frm_dlc,
    output wire [63:0] frm_data,
    output wire [15:0] frm_timestamp,
    output wire frm_own_tx,
    output wire frm_one_frame
);
    logic pend;
    logic vld_r;
    logic [116:0] stage;
    logic [116:0] f_r;

    assign frm_valid = vld_r;
    assign {frm_ide, frm_rtr, frm_id, frm_dlc, frm_data, frm_timestamp,
        frm_own_tx, frm_one_frame} = f_r;

    initial
    begin
        pend = 1'b0;
        vld_r = 1'b0;
        stage = '0;
        f_r = '0;
    end

    // ========
    // one frame every other cycle at most; fields are junk outside a frame
    always @(posedge pclk)
    begin
        if (pend)
        begin
            vld_r <= 1'b1;
            f_r <= stage;
            pend <= 1'b0;
        end
        else
        begin
            vld_r <= 1'b0;
            f_r <= 117'({$urandom, $urandom, $urandom, $urandom});
        end
    end

    task send(input logic [116:0] f);
        stage = f;
        pend <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
endmodule // can_frame_src

// ---- tb/can_rxfifo_path_props.sv ----
// concurrent checks on the ports of the receive fifo path
`timescale 1ns/10ps

module can_rxfifo_path_props #(
    parameter AW = 4,
    parameter TS_W = 16
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // frame offer and interrupts
    input wire frm_valid,
    input wire rx_irq,
    input wire full_irq,
    input wire global_err_irq
);
    // ========
    // helpers
    wire wr_acc = psel & penable & pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ========
    // bus timing
    a_ready_after_setup: assert property (
        psel && !penable |=> pready && penable)
        else $error("ready missing after setup");
    a_ready_pulse: assert property (
        pready |-> psel && penable ##1 !pready)
        else $error("ready not a single access pulse");
    a_idle_no_ready: assert property (
        !psel |=> !pready)
        else $error("ready without a request");
    a_err_read_zero: assert property (
        pslverr |-> pready && (pwrite || prdata == 32'h0000_0000))
        else $error("error response bad");
    // read data may only move when a read setup was taken
    a_rdata_hold: assert property (
        $changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved without a read");

    // ========
    // interrupts: raised by an offered frame or a write, dropped only by a write
    a_rx_rise_cause: assert property (
        $rose(rx_irq) |-> $past(frm_valid, 2) || $past(wr_acc, 2))
        else $error("rx irq rose without cause");
    a_rx_fall_sw: assert property (
        $fell(rx_irq) |-> $past(wr_acc, 2))
        else $error("rx irq dropped by itself");
    a_full_fall_sw: assert property (
        $fell(full_irq) |-> $past(wr_acc, 2))
        else $error("full irq dropped by itself");
    a_err_rise_cause: assert property (
        $rose(global_err_irq) |-> $past(frm_valid, 2) || $past(wr_acc, 2))
        else $error("error irq rose without cause");

    c_store_irq: cover property (frm_valid ##2 $rose(rx_irq));
    c_slverr: cover property (pslverr);
    c_err_irq: cover property ($rose(global_err_irq));
endmodule // can_rxfifo_path_props

// ---- tb/can_rxfifo_path_tb_top.sv ----
// self-checking testbench of the receive fifo path
`timescale 1ns/10ps
`include "can_rxfifo_map.vh"

module can_rxfifo_path_tb_top;
    typedef struct {logic [10:0] id; logic [3:0] dlc; logic [63:0] d;} ent_t;
    logic pclk, presetn, psel, penable, pwrite, err, ovw, chk, repl;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0] rdlc;
    logic [15:0] lbl;
    wire [31:0] prdata;
    wire pready, pslverr, rx_irq, full_irq, global_err_irq;
    wire frm_valid, frm_ide, frm_rtr, frm_own_tx, frm_one_frame;
    wire [28:0] frm_id;
    wire [3:0] frm_dlc;
    wire [63:0] frm_data;
    wire [15:0] frm_timestamp;
    int errors, n_tests, depth;
    ent_t q[$];

    can_rxfifo_path #(.AW(4), .TS_W(16)) can_rxfifo_path_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid),
        .frm_ide(frm_ide), .frm_rtr(frm_rtr), .frm_id(frm_id),
        .frm_dlc(frm_dlc), .frm_data(frm_data),
        .frm_timestamp(frm_timestamp), .frm_own_tx(frm_own_tx),
        .frm_one_frame(frm_one_frame), .rx_irq(rx_irq),
        .full_irq(full_irq), .global_err_irq(global_err_irq));

    can_frame_src can_frame_src_i (
        .pclk(pclk), .frm_valid(frm_valid), .frm_ide(frm_ide),
        .frm_rtr(frm_rtr), .frm_id(frm_id), .frm_dlc(frm_dlc),
        .frm_data(frm_data), .frm_timestamp(frm_timestamp),
        .frm_own_tx(frm_own_tx), .frm_one_frame(frm_one_frame));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ========
    // expectations
    function logic [31:0] exp_df(ent_t e, int w);
        logic [63:0] m;
        m = (e.dlc >= 4'h8) ? '1 : (64'h1 << (8 * e.dlc)) - 64'h1;
        m = m & e.d;
        return w ? m[63:32] : m[31:0];
    endfunction

    function logic [3:0] exp_dlc(ent_t e);
        return (chk && repl) ? rdlc : e.dlc;
    endfunction

    // ========
    // bus and checking tasks
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got,
                exp);
        end
    endtask

    task conclude;
        $display("comparisons %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        // a hung slave ends the run here instead of stalling it
        if (pready !== 1'b1)
        begin
            errors++;
            conclude;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd_exp(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, e);
    endtask

    task sts_chk;
        apb(1'b0, `OFS_FIFO_STS, 32'h0000_0000);
        check(rd[15:8], 8'(q.size()));
        check(rd[1:0], {q.size() == depth, q.size() == 0});
    endtask

    task rule(input logic c, input logic r, input logic [3:0] dl);
        chk = c;
        repl = r;
        rdlc = dl;
        lbl = 16'($urandom);
        wr(`OFS_GLB_CFG, {27'h000_0000, 4'b0111, c});
        wr(`OFS_RULE_CFG, {lbl, 10'h000, 1'b1, r, dl});
    endtask

    // disabling the fifo empties it, so the model queue restarts too
    task setup(input logic [31:0] cfg);
        wr(`OFS_FIFO_CFG, 32'h0000_0000);
        wr(`OFS_FIFO_STS, 32'h0000_0000);
        wr(`OFS_FIFO_CFG, cfg);
        depth = 4 << (cfg[10:8] - 1);
        ovw = cfg[13];
        q.delete();
    endtask

    task push_frm(input logic [3:0] dl, input logic one);
        ent_t e;
        e.id = 11'($urandom);
        e.dlc = dl;
        e.d = {$urandom, $urandom};
        if (!(chk && dl < rdlc))
        begin
            if (q.size() == depth && ovw)
                q.delete(0);
            if (q.size() < depth)
                q.push_back(e);
        end
        can_frame_src_i.send({2'b00, 18'($urandom), e.id, dl, e.d,
            16'($urandom), 1'b0, one});
    endtask

    task drain;
        ent_t e;
        while (q.size() > 0)
        begin
            e = q.pop_front();
            rd_exp(`OFS_ENT_ID_LO, {21'h00_0000, e.id});
            rd_exp(`OFS_ENT_ID_HI, 32'h0000_0000);
            rd_exp(`OFS_ENT_PTR, {exp_dlc(e), 12'h000, lbl});
            rd_exp(`OFS_ENT_DF0, exp_df(e, 0));
            rd_exp(`OFS_ENT_DF1, exp_df(e, 1));
            wr(`OFS_PTR_CTRL, 32'h0000_00ff);
            sts_chk;
        end
    endtask

    // ========
    // main sequence
    initial
    begin
        {psel, penable, pwrite, err, ovw, chk, repl} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        {rdlc, lbl, errors, n_tests, depth} = '0;
        presetn = 1'b0;
        void'($urandom(32'h5a87_03a7));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_exp(`OFS_FIFO_STS, 32'h0000_0001);
        wr(`OFS_RULE_MASK, 32'h0000_0000);
        // four deep, irq per message, history bit set to no effect
        rule(1'b1, 1'b0, 4'h0);
        setup(32'h0000_4939);
        repeat (5) push_frm(4'($urandom_range(8, 0)), 1'b0);
        sts_chk;
        check({rx_irq, full_irq, global_err_irq}, 3'b111);
        apb(1'b0, `OFS_FIFO_STS, 32'h0000_0000);
        check(rd[6:2], 5'b01101);
        wr(`OFS_PTR_CTRL, 32'h0000_00fe);
        sts_chk;
        wr(`OFS_GLB_CFG, 32'h0000_0007);
        rd_exp(`OFS_ENT_ID_LO, 32'h0000_0000);
        wr(`OFS_GLB_CFG, 32'h0000_000f);
        drain;
        wr(`OFS_PTR_CTRL, 32'h0000_00ff);
        sts_chk;
        wr(`OFS_FIFO_CFG, 32'h0000_4938);
        sts_chk;
        check({rx_irq, full_irq}, 2'b11);
        wr(`OFS_FIFO_STS, 32'h0000_0000);
        sts_chk;
        check({rx_irq, full_irq, global_err_irq}, 3'b000);
        // eight deep, half-full threshold, overwrite, one-frame irq
        rule(1'b1, 1'b1, 4'h3);
        setup(32'h0000_3269);
        repeat (3) push_frm(4'($urandom_range(8, 3)), 1'b1);
        push_frm(4'h1, 1'b1);
        sts_chk;
        check(rx_irq, 1'b0);
        push_frm(4'h3, 1'b1);
        sts_chk;
        check(rx_irq, 1'b1);
        repeat (6) push_frm(4'($urandom_range(8, 3)), 1'b1);
        sts_chk;
        check({full_irq, global_err_irq}, 2'b11);
        apb(1'b0, `OFS_FIFO_STS, 32'h0000_0000);
        check(rd[6:2], 5'b10110);
        drain;
        // replacement needs the global check as well
        rule(1'b0, 1'b1, 4'h3);
        setup(32'h0000_0939);
        push_frm(4'h2, 1'b0);
        drain;
        rd_exp(8'hfc, 32'h0000_0000);
        check(err, 1'b1);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_exp(`OFS_FIFO_STS, 32'h0000_0001);
        conclude;
    end
endmodule // can_rxfifo_path_tb_top

bind can_rxfifo_path can_rxfifo_path_props #(.AW(AW), .TS_W(TS_W))
    can_rxfifo_path_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frm_valid(frm_valid), .rx_irq(rx_irq), .full_irq(full_irq),
    .global_err_irq(global_err_irq));
